// >>> rtl/serial_irq_controller.v
// serial interrupt line controller with its configuration registers
//
// Overview of operation
// - start frame 4, 6 or 8 clocks
// - poll select 0 continuous, 1 quiet
// - recovery drives high, or floats when selected
// - one edge/level select bit per slot
// - level slot signalled sets matching status bit
// - writing one clears status and re-arms it
// - edge slots never set status bits
// - express, global or power-on reset restores defaults
// - mode bits 7:4 read zero, ignore writes
`timescale 1ns/100ps
`default_nettype none
`include "serial_irq_defines.vh"

module serial_irq_controller
(
    input wire clk,
    input wire srst,
    input wire express_reset,
    input wire global_reset_input,
    input wire [7:0] cfg_addr,
    input wire [3:0] cfg_byte_en,
    input wire cfg_write,
    input wire [31:0] cfg_write_data,
    input wire cfg_read,
    output reg [31:0] cfg_read_data,
    output reg cfg_read_valid,
    input wire serial_interrupt_line_in,
    output reg serial_interrupt_line_out,
    output reg serial_interrupt_line_oe,
    output reg [15:0] slot_state,
    output reg frame_done
);

////////////////////////////////////////////////////////////////////////////
// frame states

localparam [3:0] ST_IDLE = 4'h0;
localparam [3:0] ST_START = 4'h1;
localparam [3:0] ST_START_REC = 4'h2;
localparam [3:0] ST_START_TA = 4'h3;
localparam [3:0] ST_SLOT_SAMPLE = 4'h4;
localparam [3:0] ST_SLOT_REC = 4'h5;
localparam [3:0] ST_SLOT_TA = 4'h6;
localparam [3:0] ST_STOP = 4'h7;
localparam [3:0] ST_STOP_REC = 4'h8;
localparam [3:0] ST_STOP_TA = 4'h9;

////////////////////////////////////////////////////////////////////////////
// declarations

wire rst;
reg [7:0] serial_interrupt_mode_control;
reg [15:0] serial_interrupt_trigger_select;
wire [15:0] serial_interrupt_level_status;
wire poll_select;
wire recovery_drive_select;
wire [1:0] start_code;
reg [3:0] start_len;
reg [3:0] state;
reg [3:0] next_state;
reg [3:0] phase_count;
reg [3:0] next_phase_count;
reg [3:0] slot;
reg [3:0] next_slot;
reg next_line_out;
reg next_line_oe;
wire mode_hit;
wire status_hit;
wire slot_signalled;
wire [15:0] slot_onehot;
wire [15:0] level_set;
wire [15:0] level_clear;
reg [31:0] next_read_data;
reg [7:0] next_mode;

// any of the three resets restores the defaults
assign rst = srst | express_reset | global_reset_input;

assign poll_select = serial_interrupt_mode_control[`SIRQ_POLL_SELECT_BIT];
assign recovery_drive_select =
    serial_interrupt_mode_control[`SIRQ_RECOVERY_DRIVE_BIT];
assign start_code = serial_interrupt_mode_control[
    `SIRQ_START_WIDTH_MSB:`SIRQ_START_WIDTH_LSB];

////////////////////////////////////////////////////////////////////////////
// start frame length

// the reserved code falls back to the shortest start
always @*
begin
    case (start_code)
        `SIRQ_START_CODE_6:
        begin
            start_len = `SIRQ_START_CLOCKS_6;
        end
        `SIRQ_START_CODE_8:
        begin
            start_len = `SIRQ_START_CLOCKS_8;
        end
        default:
        begin
            start_len = `SIRQ_START_CLOCKS_4;
        end
    endcase
end

////////////////////////////////////////////////////////////////////////////
// frame sequencer

always @*
begin
    next_state = state;
    next_phase_count = phase_count;
    next_slot = slot;
    case (state)
        ST_IDLE:
        begin
            if (!poll_select)
            begin
                next_state = ST_START;
                next_phase_count = start_len - 4'h1;
            end
            // in quiet mode a source opens the frame with one low clock
            else if (!serial_interrupt_line_in)
            begin
                next_state = ST_START;
                next_phase_count = start_len - 4'h2;
            end
        end
        ST_START:
        begin
            if (phase_count == 4'h0)
            begin
                next_state = ST_START_REC;
            end
            else
            begin
                next_phase_count = phase_count - 4'h1;
            end
        end
        ST_START_REC:
        begin
            next_state = ST_START_TA;
        end
        ST_START_TA:
        begin
            next_state = ST_SLOT_SAMPLE;
            next_slot = 4'h0;
        end
        ST_SLOT_SAMPLE:
        begin
            next_state = ST_SLOT_REC;
        end
        ST_SLOT_REC:
        begin
            next_state = ST_SLOT_TA;
        end
        ST_SLOT_TA:
        begin
            if (slot == `SIRQ_LAST_SLOT)
            begin
                next_state = ST_STOP;
                // stop width tells the sources which mode follows
                if (poll_select)
                begin
                    next_phase_count = `SIRQ_STOP_CLOCKS_QUIET - 4'h1;
                end
                else
                begin
                    next_phase_count = `SIRQ_STOP_CLOCKS_CONTINUOUS - 4'h1;
                end
            end
            else
            begin
                next_state = ST_SLOT_SAMPLE;
                next_slot = slot + 4'h1;
            end
        end
        ST_STOP:
        begin
            if (phase_count == 4'h0)
            begin
                next_state = ST_STOP_REC;
            end
            else
            begin
                next_phase_count = phase_count - 4'h1;
            end
        end
        ST_STOP_REC:
        begin
            next_state = ST_STOP_TA;
        end
        ST_STOP_TA:
        begin
            next_state = ST_IDLE;
        end
        default:
        begin
            next_state = ST_IDLE;
        end
    endcase
end

// line drive follows the next state so the pin changes with the state
always @*
begin
    next_line_out = 1'b1;
    next_line_oe = 1'b0;
    case (next_state)
        ST_START, ST_STOP:
        begin
            next_line_out = 1'b0;
            next_line_oe = 1'b1;
        end
        ST_START_REC, ST_STOP_REC:
        begin
            next_line_out = 1'b1;
            next_line_oe = ~recovery_drive_select;
        end
        default:
        begin
            next_line_out = 1'b1;
            next_line_oe = 1'b0;
        end
    endcase
end

always @(posedge clk)
begin
    if (rst)
    begin
        state <= ST_IDLE;
        phase_count <= 4'h0;
        slot <= 4'h0;
        serial_interrupt_line_out <= 1'b1;
        serial_interrupt_line_oe <= 1'b0;
    end
    else
    begin
        state <= next_state;
        phase_count <= next_phase_count;
        slot <= next_slot;
        serial_interrupt_line_out <= next_line_out;
        serial_interrupt_line_oe <= next_line_oe;
    end
end

////////////////////////////////////////////////////////////////////////////
// slot sampling

// a source pulls the line low in the sample clock of its slot
assign slot_signalled = (state == ST_SLOT_SAMPLE) &
    ~serial_interrupt_line_in;
assign slot_onehot = 16'h0001 << slot;

// only level slots reach the status register
assign level_set = slot_signalled ?
    (slot_onehot & serial_interrupt_trigger_select) : 16'h0000;

always @(posedge clk)
begin
    if (rst)
    begin
        slot_state <= 16'h0000;
        frame_done <= 1'b0;
    end
    else
    begin
        frame_done <= (state == ST_STOP_TA);
        if (state == ST_SLOT_SAMPLE)
        begin
            slot_state[slot] <= ~serial_interrupt_line_in;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// configuration registers

assign mode_hit = (cfg_addr & `SIRQ_DWORD_MASK) == `SIRQ_MODE_CONTROL_OFFSET;
assign status_hit = (cfg_addr & `SIRQ_DWORD_MASK) ==
    `SIRQ_LEVEL_STATUS_OFFSET;

assign level_clear = (cfg_write && status_hit) ?
    ({{8{cfg_byte_en[1]}}, {8{cfg_byte_en[0]}}} &
    cfg_write_data[15:0]) : 16'h0000;

serial_irq_status_bits u_status
(
    .clk(clk),
    .rst(rst),
    .set_vec(level_set),
    .clear_vec(level_clear),
    .status(serial_interrupt_level_status)
);

always @*
begin
    next_mode = serial_interrupt_mode_control;
    if (cfg_write && mode_hit && cfg_byte_en[0])
    begin
        // upper nibble stays zero whatever is written
        next_mode = cfg_write_data[7:0] & `SIRQ_MODE_WRITE_MASK;
    end
end

always @(posedge clk)
begin
    if (rst)
    begin
        serial_interrupt_mode_control <= `SIRQ_MODE_CONTROL_RESET;
        serial_interrupt_trigger_select <= `SIRQ_TRIGGER_SELECT_RESET;
    end
    else
    begin
        serial_interrupt_mode_control <= next_mode;
        if (cfg_write && mode_hit && cfg_byte_en[2])
        begin
            serial_interrupt_trigger_select[7:0] <=
                cfg_write_data[23:16];
        end
        if (cfg_write && mode_hit && cfg_byte_en[3])
        begin
            serial_interrupt_trigger_select[15:8] <=
                cfg_write_data[31:24];
        end
    end
end

// unmapped dwords and unused bytes read as zero
always @*
begin
    next_read_data = 32'h00000000;
    if (mode_hit)
    begin
        next_read_data = {serial_interrupt_trigger_select, 8'h00,
            serial_interrupt_mode_control & `SIRQ_MODE_WRITE_MASK};
    end
    else if (status_hit)
    begin
        next_read_data = {16'h0000, serial_interrupt_level_status};
    end
end

always @(posedge clk)
begin
    if (rst)
    begin
        cfg_read_data <= 32'h00000000;
        cfg_read_valid <= 1'b0;
    end
    else
    begin
        cfg_read_valid <= cfg_read;
        if (cfg_read)
        begin
            cfg_read_data <= next_read_data;
        end
    end
end

endmodule
`default_nettype wire

// >>> rtl/serial_irq_defines.vh
// constants for the serial interrupt controller: offsets, fields, resets, counts
`ifndef SERIAL_IRQ_DEFINES_VH
`define SERIAL_IRQ_DEFINES_VH

// configuration byte offsets and the dword that holds each
`define SIRQ_MODE_CONTROL_OFFSET 8'hE0
`define SIRQ_TRIGGER_SELECT_OFFSET 8'hE2
`define SIRQ_LEVEL_STATUS_OFFSET 8'hE4
`define SIRQ_DWORD_MASK 8'hFC

// mode control fields
`define SIRQ_RECOVERY_DRIVE_BIT 0
`define SIRQ_POLL_SELECT_BIT 1
`define SIRQ_START_WIDTH_LSB 2
`define SIRQ_START_WIDTH_MSB 3
`define SIRQ_MODE_WRITE_MASK 8'h0F

// reset values
`define SIRQ_MODE_CONTROL_RESET 8'h00
`define SIRQ_TRIGGER_SELECT_RESET 16'h0000
`define SIRQ_LEVEL_STATUS_RESET 16'h0000

// start frame width codes and lengths in clocks
`define SIRQ_START_CODE_4 2'h0
`define SIRQ_START_CODE_6 2'h1
`define SIRQ_START_CODE_8 2'h2
`define SIRQ_START_CLOCKS_4 4'h4
`define SIRQ_START_CLOCKS_6 4'h6
`define SIRQ_START_CLOCKS_8 4'h8

// stop frame lengths in clocks: quiet and continuous
`define SIRQ_STOP_CLOCKS_QUIET 4'h2
`define SIRQ_STOP_CLOCKS_CONTINUOUS 4'h3

// interrupt slots per frame
`define SIRQ_SLOT_COUNT 16
`define SIRQ_LAST_SLOT 4'hF

`endif

// >>> rtl/serial_irq_status_bits.v
// sticky level-interrupt status bits, set by the frame, cleared by write-one
`timescale 1ns/100ps
`default_nettype none
`include "serial_irq_defines.vh"

module serial_irq_status_bits
(
    input wire clk,
    input wire rst,
    input wire [15:0] set_vec,
    input wire [15:0] clear_vec,
    output wire [15:0] status
);

reg [15:0] status_bits;
wire [15:0] reset_bits;

assign reset_bits = `SIRQ_LEVEL_STATUS_RESET;

genvar i;
generate
    for (i = 0; i < `SIRQ_SLOT_COUNT; i = i + 1)
    begin : g_bit
        always @(posedge clk)
        begin
            if (rst)
            begin
                status_bits[i] <= reset_bits[i];
            end
            // a slot seen in the same cycle as its clear stays reported
            else if (set_vec[i])
            begin
                status_bits[i] <= 1'b1;
            end
            else if (clear_vec[i])
            begin
                status_bits[i] <= 1'b0;
            end
        end
    end
endgenerate

assign status = status_bits;

endmodule
`default_nettype wire

// >>> verif/serial_irq_controller_properties.sv
// port checker for the serial interrupt controller
`timescale 1ns/100ps
`default_nettype none
module serial_irq_controller_properties
(
    input wire logic clk,
    input wire logic srst,
    input wire logic express_reset,
    input wire logic global_reset_input,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_byte_en,
    input wire logic cfg_write,
    input wire logic [31:0] cfg_write_data,
    input wire logic cfg_read,
    input wire logic [31:0] cfg_read_data,
    input wire logic cfg_read_valid,
    input wire logic serial_interrupt_line_in,
    input wire logic serial_interrupt_line_out,
    input wire logic serial_interrupt_line_oe,
    input wire logic [15:0] slot_state,
    input wire logic frame_done
);
    wire rst = srst | express_reset | global_reset_input;
    wire ln = serial_interrupt_line_in;
    wire oe = serial_interrupt_line_oe;
    wire out = serial_interrupt_line_out;
    wire e0 = (cfg_addr & 8'hFC) == 8'hE0;
    logic [3:0] mode;
    logic [15:0] trig;
    logic [3:0] low_run;
    logic [6:0] gap;
    logic cont;
    // reserved width code runs as four clocks
    wire [3:0] w = mode[3:2] == 2'h1 ? 4'h6 : mode[3:2] == 2'h2 ? 4'h8 : 4'h4;
    wire [3:0] s = mode[1] ? 4'h2 : 4'h3;
    wire lo = oe & ~out;
    ////////////////////////////////////////
    // shadow registers follow the writes so the frame can be judged
    always @(posedge clk)
    begin
        if (rst)
        begin
            mode <= 4'h0;
            trig <= 16'h0000;
            low_run <= 4'h0;
            gap <= 7'h00;
            cont <= 1'b0;
        end
        else
        begin
            if (cfg_write && e0 && cfg_byte_en[0])
                mode <= cfg_write_data[3:0];
            if (cfg_write && e0 && cfg_byte_en[2])
                trig[7:0] <= cfg_write_data[23:16];
            if (cfg_write && e0 && cfg_byte_en[3])
                trig[15:8] <= cfg_write_data[31:24];
            low_run <= ln ? 4'h0 : low_run + 4'h1;
            gap <= frame_done ? 7'h01 : gap + 7'h01;
            cont <= frame_done ? ~mode[1] : cont;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    a_start_width: assert property (
        ln && low_run > 4'h3 |-> low_run == w)
        else $error("start frame width wrong");
    a_stop_width: assert property (
        ln && (low_run == 4'h2 || low_run == 4'h3) |-> low_run == s)
        else $error("stop frame width wrong");
    a_recovery_drive: assert property (
        $past(lo) && !lo |-> out && oe == !mode[0] ##1 !oe)
        else $error("recovery cycle wrong");
    a_frame_period: assert property (
        frame_done && cont && !mode[1] |-> gap == w + s + 7'h35)
        else $error("continuous frame period wrong");
    a_done_pulse: assert property (frame_done |=> !frame_done)
        else $error("frame end longer than one clock");
    a_quiet_idle: assert property (
        frame_done && mode[1] |=> (!oe || !mode[1]) [*4])
        else $error("quiet mode started a frame itself");
    a_mode_read: assert property (
        cfg_read && e0 |=> cfg_read_valid
        && cfg_read_data == {$past(trig), 12'h000, $past(mode)})
        else $error("mode or trigger readback wrong");
    a_reset_idle: assert property (disable iff (1'b0)
        rst |=> !oe && out && !frame_done && !cfg_read_valid
        && slot_state == 16'h0000 && cfg_read_data == 32'h0000_0000)
        else $error("reset state wrong");
endmodule
bind serial_irq_controller serial_irq_controller_properties u_props
(
    .clk(clk),
    .srst(srst),
    .express_reset(express_reset),
    .global_reset_input(global_reset_input),
    .cfg_addr(cfg_addr),
    .cfg_byte_en(cfg_byte_en),
    .cfg_write(cfg_write),
    .cfg_write_data(cfg_write_data),
    .cfg_read(cfg_read),
    .cfg_read_data(cfg_read_data),
    .cfg_read_valid(cfg_read_valid),
    .serial_interrupt_line_in(serial_interrupt_line_in),
    .serial_interrupt_line_out(serial_interrupt_line_out),
    .serial_interrupt_line_oe(serial_interrupt_line_oe),
    .slot_state(slot_state),
    .frame_done(frame_done)
);
`default_nettype wire

// >>> verif/serial_irq_source_model.sv
// behavioural interrupt sources sharing the serial line
`timescale 1ns/100ps
`default_nettype none
module serial_irq_source_model
(
    input wire logic clk,
    input wire logic line,
    input wire logic [15:0] assert_mask,
    output logic drive_low
);
    int low_run = 0;
    int pos = 999;
    initial drive_low = 1'b0;
    always @(posedge clk)
    begin
        // four low clocks or more can only be a start frame
        if (line !== 1'b0 && low_run > 3)
            pos = 0;
        else if (pos < 999)
            pos++;
        low_run = line === 1'b0 ? low_run + 1 : 0;
        // low for the whole sample clock of each chosen slot only
        drive_low <= #1 pos % 3 == 1 && pos < 47
            && assert_mask[(pos - 1) / 3];
    end
endmodule
`default_nettype wire

// >>> verif/serial_irq_controller_tb.sv
// self-checking bench for the serial interrupt controller
`timescale 1ns/100ps
`default_nettype none
module serial_irq_controller_tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic express_reset = 1'b0;
    logic global_reset_input = 1'b0;
    logic [7:0] cfg_addr = 8'h00;
    logic [3:0] cfg_byte_en = 4'h0;
    logic cfg_write = 1'b0;
    logic [31:0] cfg_write_data = 32'h0000_0000;
    logic cfg_read = 1'b0;
    wire [31:0] cfg_read_data;
    wire cfg_read_valid;
    wire serial_interrupt_line_out;
    wire serial_interrupt_line_oe;
    wire [15:0] slot_state;
    wire frame_done;
    wire src_low;
    logic wake = 1'b0;
    logic [15:0] pull = 16'h0000;
    logic [31:0] got;
    int fails = 0;
    int checks = 0;
    // pull-up on the shared line
    wire serial_interrupt_line_in = ~src_low & ~wake
        & (serial_interrupt_line_oe ? serial_interrupt_line_out : 1'b1);
    serial_irq_controller u_serial_irq_controller
    (
        .clk(clk),
        .srst(srst),
        .express_reset(express_reset),
        .global_reset_input(global_reset_input),
        .cfg_addr(cfg_addr),
        .cfg_byte_en(cfg_byte_en),
        .cfg_write(cfg_write),
        .cfg_write_data(cfg_write_data),
        .cfg_read(cfg_read),
        .cfg_read_data(cfg_read_data),
        .cfg_read_valid(cfg_read_valid),
        .serial_interrupt_line_in(serial_interrupt_line_in),
        .serial_interrupt_line_out(serial_interrupt_line_out),
        .serial_interrupt_line_oe(serial_interrupt_line_oe),
        .slot_state(slot_state),
        .frame_done(frame_done)
    );
    serial_irq_source_model u_serial_irq_source_model (.clk(clk),
        .line(serial_interrupt_line_in), .assert_mask(pull),
        .drive_low(src_low));
    always #25 clk = ~clk;
    ////////////////////////////////////////
    task results;
    begin
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
    begin
        checks++;
        if (g !== e)
        begin
            fails++;
            $display("Error %0t: got %h want %h", $time, g, e);
        end
    end
    endtask
    task acc(input logic w, input logic [7:0] a, input logic [3:0] b,
        input logic [31:0] d);
    begin
        @(posedge clk);
        #1;
        cfg_addr = a;
        cfg_byte_en = b;
        cfg_write_data = d;
        cfg_write = w;
        cfg_read = ~w;
        @(posedge clk);
        #1;
        cfg_write = 1'b0;
        cfg_read = 1'b0;
        got = cfg_read_data;
    end
    endtask
    task frame;
    begin
        repeat (300)
        begin
            @(posedge clk);
            #1;
            if (frame_done === 1'b1)
                return;
        end
        fails++;
        $display("Error %0t: no frame end", $time);
    end
    endtask
    // a source opens a quiet-mode frame with one low clock
    task kick;
    begin
        repeat (5) @(posedge clk);
        #1;
        wake = 1'b1;
        @(posedge clk);
        #1;
        wake = 1'b0;
    end
    endtask
    ////////////////////////////////////////
    task t_regs;
    begin
        acc(1'b0, 8'hE0, 4'hF, 32'h0);
        chk(got, 32'h0000_0000);
        acc(1'b0, 8'hE4, 4'hF, 32'h0);
        chk(got, 32'h0000_0000);
        acc(1'b1, 8'hE0, 4'hF, 32'h00FF_FFF2);
        acc(1'b0, 8'hE0, 4'hF, 32'h0);
        chk(got, 32'h00FF_0002);
        acc(1'b0, 8'hE8, 4'hF, 32'h0);
        chk(got, 32'h0000_0000);
        frame;
    end
    endtask
    task t_level;
    begin
        pull = 16'h8181;
        kick;
        frame;
        chk({16'h0000, slot_state}, 32'h0000_8181);
        acc(1'b0, 8'hE4, 4'hF, 32'h0);
        chk(got, 32'h0000_0081);
        acc(1'b1, 8'hE4, 4'h1, 32'h0000_0001);
        acc(1'b0, 8'hE4, 4'hF, 32'h0);
        chk(got, 32'h0000_0080);
        pull = 16'h0001;
        kick;
        frame;
        acc(1'b0, 8'hE4, 4'hF, 32'h0);
        chk(got, 32'h0000_0081);
    end
    endtask
    task t_widths;
        int n;
    begin
        for (int c = 0; c < 4; c++)
        begin
            acc(1'b1, 8'hE0, 4'h1, {28'h0, c[1:0], 1'b1, c[0]});
            kick;
            n = 1;
            while (serial_interrupt_line_in === 1'b0 && n < 20)
            begin
                @(posedge clk);
                #1;
                n++;
            end
            chk(n, c == 1 ? 6 : c == 2 ? 8 : 4);
            chk({31'h0, serial_interrupt_line_oe}, {31'h0, ~c[0]});
            frame;
        end
    end
    endtask
    task t_cont;
        time t;
    begin
        acc(1'b1, 8'hE0, 4'h1, 32'h0000_0004);
        frame;
        t = $time;
        frame;
        chk((($time - t) / 50), 32'h0000_003E);
        pull = 16'h0000;
        acc(1'b1, 8'hE0, 4'h1, 32'h0000_0006);
        frame;
    end
    endtask
    task t_resets;
    begin
        for (int r = 0; r < 3; r++)
        begin
            acc(1'b1, 8'hE0, 4'hD, 32'hFFFF_000E);
            @(posedge clk);
            #1;
            {global_reset_input, express_reset, srst} = 3'b001 << r;
            @(posedge clk);
            #1;
            {global_reset_input, express_reset, srst} = 3'b000;
            acc(1'b0, 8'hE0, 4'hF, 32'h0);
            chk(got, 32'h0000_0000);
            acc(1'b0, 8'hE4, 4'hF, 32'h0);
            chk(got, 32'h0000_0000);
        end
    end
    endtask
    ////////////////////////////////////////
    initial
    begin
        #200000;
        fails++;
        $display("Error %0t: watchdog expired", $time);
        results;
    end
    initial
    begin
        repeat (3) @(posedge clk);
        #1;
        srst = 1'b0;
        t_regs;
        t_level;
        t_widths;
        t_cont;
        t_resets;
        results;
    end
endmodule
`default_nettype wire
